//--- hw/asp_entity_parser.sv
`timescale 1ns/10ps
`include "asp_defines.svh"

// Function
// - alt body opens flag, slot, flags, code
// - slot flag selects service or notice slot
// - area/timetable byte present only when flagged
// - area index zero means unspecified
// - timetable index zero means unspecified
// - report identical-programme flag as sent
// - sender zeroes the two spare bits
// - identifier length follows system code
// - reserved system codes decode nothing
// - country prefix precedes identification code
// - zero to sixteen frequency entries
// - entry width 16 or 8 by code
// - 16-bit entry: spare bit, 15-bit kHz
// - first fm grid: 87.5 MHz plus steps
// - second fm grid: 76.0 MHz plus steps
// - classify digital audio channel bands
// - sender sends identifier or frequency, never neither
// - language entity: slot, spare, language, country
// - three hyphens mean unspecified language
// - two hyphens mean unspecified country
// - unknown entity types passed by

// receiving end: parses entity bodies from the link
module asp_entity_parser
    import asp_pkg::*;
(
    // clock and reset
    input  wire logic           sys_clk_i,
    input  wire logic           nrst_i,
    // link
    asp_link_if.dev             lk,
    // per-frequency result
    output logic                freq_valid_o,
    output logic [7:0]          freq_code_o,
    output logic [16:0]         freq_khz_o,
    output asp_pkg::asp_dab_t   dab_band_o,
    // per-entity record
    output logic                rec_valid_o,
    output logic [3:0]          rec_type_o,
    output logic                notice_o,
    output logic [1:0]          slot_o,
    output logic                area_en_o,
    output logic [3:0]          area_o,
    output logic                area_spec_o,
    output logic [3:0]          tt_o,
    output logic                tt_spec_o,
    output logic                same_prog_o,
    output logic [4:0]          sys_o,
    output logic [31:0]         fsi_o,
    output logic [5:0]          fsi_bits_o,
    output logic [4:0]          nfreq_o,
    output logic [23:0]         lang_o,
    output logic                lang_unspec_o,
    output logic [15:0]         country_o,
    output logic                country_unspec_o,
    output logic                err_o
);
    import asp_pkg::*;

    asp_state_t            state_q;
    logic [5:0]            cnt_q;
    logic [`ASP_SHIFT_W-1:0] sh_q;
    logic [`ASP_SHIFT_W-1:0] val;
    logic [5:0]            flen;
    logic                  take;
    logic                  fdone;
    logic                  rdy_q;
    logic [3:0]            type_q;
    logic                  notice_q;
    logic [1:0]            slot_q;
    logic                  area_en_q;
    logic [3:0]            area_q;
    logic [3:0]            tt_q;
    logic                  same_q;
    logic [4:0]            sys_q;
    logic [31:0]           fsi_q;
    logic [4:0]            nf_q;
    logic [23:0]           lang_q;
    logic [15:0]           ctry_q;
    logic                  err_q;
    logic                  rec_valid_q;
    logic                  freq_valid_q;
    logic [7:0]            fcode_q;
    logic [16:0]           fkhz_q;
    asp_dab_t              dab_q;
    logic                  fbad;
    logic [16:0]           fkhz;
    asp_dab_t              dab;
    logic                  lang_bad;

    // lower case letter or hyphen check
    function automatic logic asp_chr_ok(input logic [7:0] c);
        asp_chr_ok = (c == `ASP_HYPHEN) || (c >= `ASP_LOWER_A && c <= `ASP_LOWER_Z);
    endfunction

    // --------------------------------------------------------
    // field framing
    // --------------------------------------------------------
    assign take = lk.valid && lk.ready;
    assign val  = {sh_q[`ASP_SHIFT_W-2:0], lk.data};

    // length of the field now being gathered
    always_comb begin
        case (state_q)
            ASP_S_HDR:  flen = `ASP_HDR_BITS;
            ASP_S_AREA: flen = `ASP_AREA_BITS;
            ASP_S_ID:   flen = asp_id_bits(sys_q);
            ASP_S_FREQ: flen = asp_freq_bits(sys_q);
            ASP_S_LANG: flen = `ASP_LANG_BITS;
            default:    flen = 6'h01;
        endcase
    end
    assign fdone = take && (cnt_q == flen - 6'h01);

    // --------------------------------------------------------
    // frequency decode
    // --------------------------------------------------------
    always_comb begin
        fkhz = 17'h00000;
        dab  = ASP_DAB_NONE;
        fbad = 1'b0;
        if (sys_q <= `ASP_SYS_AM_MAX) begin
            fkhz = {2'b00, val[14:0]};
        end else if (sys_q <= `ASP_SYS_FM1_MAX) begin
            fkhz = `ASP_FM1_BASE + 17'(val[7:0]) * `ASP_FM_STEP;
            fbad = val[7:0] > `ASP_FM1_MAX;
        end else if (sys_q <= `ASP_SYS_FM2_MAX) begin
            fkhz = `ASP_FM2_BASE + 17'(val[7:0]) * `ASP_FM_STEP;
            fbad = val[7:0] > `ASP_FM2_MAX;
        end else begin
            if (val[7:0] <= `ASP_DAB_B1_HI)
                dab = ASP_DAB_BAND1;
            else if (val[7:0] >= `ASP_DAB_B3_LO && val[7:0] <= `ASP_DAB_B3_HI)
                dab = ASP_DAB_BAND3;
            else if (val[7:0] > `ASP_DAB_B3_HI && val[7:0] <= `ASP_DAB_B3X_HI)
                dab = ASP_DAB_BAND3X;
            else if (val[7:0] >= `ASP_DAB_LEU_LO && val[7:0] <= `ASP_DAB_LEU_HI)
                dab = ASP_DAB_LEU;
            else if (val[7:0] >= `ASP_DAB_LCA_LO && val[7:0] <= `ASP_DAB_LCA_HI)
                dab = ASP_DAB_LCA;
            fbad = (dab == ASP_DAB_NONE);
        end
    end

    // character checks on the language entity
    assign lang_bad = !(asp_chr_ok(val[39:32]) && asp_chr_ok(val[31:24]) &&
                        asp_chr_ok(val[23:16]) && asp_chr_ok(val[15:8]) &&
                        asp_chr_ok(val[7:0]));

    // --------------------------------------------------------
    // state and shifter
    // --------------------------------------------------------
    // sequencing through the body fields
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            state_q <= ASP_S_IDLE;
            cnt_q   <= 6'h00;
            sh_q    <= '0;
        end else if (take) begin
            sh_q  <= val;
            cnt_q <= fdone ? 6'h00 : cnt_q + 6'h01;
            if (lk.last) begin
                state_q <= ASP_S_IDLE;
                cnt_q   <= 6'h00;
            end else begin
                case (state_q)
                    ASP_S_IDLE: begin
                        cnt_q <= 6'h01;
                        if (lk.ent_type == `ASP_TYPE_ALT)
                            state_q <= ASP_S_HDR;
                        else if (lk.ent_type == `ASP_TYPE_LANG)
                            state_q <= ASP_S_LANG;
                        else
                            state_q <= ASP_S_SKIP;
                    end
                    ASP_S_HDR: if (fdone) begin
                        if (val[4:0] > `ASP_SYS_MAX)
                            state_q <= ASP_S_SKIP;
                        else if (val[8])
                            state_q <= ASP_S_AREA;
                        else if (asp_id_bits(val[4:0]) != 6'h00)
                            state_q <= ASP_S_ID;
                        else
                            state_q <= ASP_S_FREQ;
                    end
                    ASP_S_AREA: if (fdone) begin
                        state_q <= (asp_id_bits(sys_q) != 6'h00) ? ASP_S_ID : ASP_S_FREQ;
                    end
                    ASP_S_ID: if (fdone) begin
                        state_q <= ASP_S_FREQ;
                    end
                    ASP_S_LANG: if (fdone) begin
                        state_q <= ASP_S_SKIP;
                    end
                    default: state_q <= state_q;
                endcase
            end
        end
    end

    // --------------------------------------------------------
    // field capture
    // --------------------------------------------------------
    // header fields latch as each field completes
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            type_q    <= 4'h0;
            notice_q  <= 1'b0;
            slot_q    <= 2'h0;
            area_en_q <= 1'b0;
            area_q    <= 4'h0;
            tt_q      <= 4'h0;
            same_q    <= 1'b0;
            sys_q     <= 5'h00;
            fsi_q     <= 32'h00000000;
            lang_q    <= 24'h000000;
            ctry_q    <= 16'h0000;
        end else if (take) begin
            if (state_q == ASP_S_IDLE) begin
                type_q    <= lk.ent_type;
                area_en_q <= 1'b0;
                area_q    <= 4'h0;
                tt_q      <= 4'h0;
                fsi_q     <= 32'h00000000;
            end
            if (state_q == ASP_S_HDR && fdone) begin
                notice_q  <= val[11];
                slot_q    <= val[10:9];
                area_en_q <= val[8];
                same_q    <= val[7];
                sys_q     <= val[4:0];
            end
            if (state_q == ASP_S_AREA && fdone) begin
                area_q <= val[7:4];
                tt_q   <= val[3:0];
            end
            // identifier kept right aligned, prefix on top
            // earlier field bits still in the shifter are masked off
            if (state_q == ASP_S_ID && fdone)
                fsi_q <= val[31:0] & ~(32'hFFFFFFFF << asp_id_bits(sys_q));
            if (state_q == ASP_S_LANG && fdone) begin
                slot_q <= val[43:42];
                lang_q <= val[39:16];
                ctry_q <= val[15:0];
            end
        end
    end

    // --------------------------------------------------------
    // counts, errors and result strobes
    // --------------------------------------------------------
    // entries counted as whole widths arrive; a short tail is dropped
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            rdy_q        <= 1'b0;
            nf_q         <= 5'h00;
            err_q        <= 1'b0;
            rec_valid_q  <= 1'b0;
            freq_valid_q <= 1'b0;
            fcode_q      <= 8'h00;
            fkhz_q       <= 17'h00000;
            dab_q        <= ASP_DAB_NONE;
        end else begin
            rdy_q        <= 1'b1;
            rec_valid_q  <= take && lk.last;
            freq_valid_q <= 1'b0;
            if (take && state_q == ASP_S_IDLE) begin
                nf_q  <= 5'h00;
                err_q <= 1'b0;
            end
            if (state_q == ASP_S_HDR && fdone && val[4:0] > `ASP_SYS_MAX)
                err_q <= 1'b1;
            if (state_q == ASP_S_FREQ && fdone) begin
                if (nf_q == `ASP_MAX_FREQ) begin
                    err_q <= 1'b1;
                end else begin
                    nf_q         <= nf_q + 5'h01;
                    freq_valid_q <= 1'b1;
                    fcode_q      <= val[7:0];
                    fkhz_q       <= fkhz;
                    dab_q        <= dab;
                    if (fbad)
                        err_q <= 1'b1;
                end
            end
            if (take && lk.last && type_q == `ASP_TYPE_ALT && state_q != ASP_S_SKIP &&
                asp_id_bits(sys_q) == 6'h00 && nf_q == 5'h00 &&
                !(state_q == ASP_S_FREQ && fdone))
                err_q <= 1'b1;
            if (state_q == ASP_S_LANG && fdone && lang_bad)
                err_q <= 1'b1;
        end
    end

    // --------------------------------------------------------
    // outputs
    // --------------------------------------------------------
    assign lk.ready         = rdy_q;
    assign freq_valid_o     = freq_valid_q;
    assign freq_code_o      = fcode_q;
    assign freq_khz_o       = fkhz_q;
    assign dab_band_o       = dab_q;
    assign rec_valid_o      = rec_valid_q;
    assign rec_type_o       = type_q;
    assign notice_o         = notice_q;
    assign slot_o           = slot_q;
    assign area_en_o        = area_en_q;
    assign area_o           = area_q;
    assign tt_o             = tt_q;
    assign same_prog_o      = same_q;
    assign sys_o            = sys_q;
    assign fsi_o            = fsi_q;
    assign fsi_bits_o       = asp_id_bits(sys_q);
    assign nfreq_o          = nf_q;
    assign lang_o           = lang_q;
    assign country_o        = ctry_q;
    assign area_spec_o      = (area_q != 4'h0);
    assign tt_spec_o        = (tt_q != 4'h0);
    assign lang_unspec_o    = (lang_q == {3{`ASP_HYPHEN}});
    assign country_unspec_o = (ctry_q == {2{`ASP_HYPHEN}});
    assign err_o            = err_q;

endmodule // asp_entity_parser

//--- inc/asp_defines.svh
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH

// ----------------------------------------------------------------
// entity types
// ----------------------------------------------------------------
`define ASP_TYPE_ALT      4'hB
`define ASP_TYPE_LANG     4'hC

// ----------------------------------------------------------------
// field widths in bits, frequency entry limit
// ----------------------------------------------------------------
`define ASP_HDR_BITS      6'h0C
`define ASP_AREA_BITS     6'h08
`define ASP_LANG_BITS     6'h2C
`define ASP_SHIFT_W       44
`define ASP_FRAME_W       320
`define ASP_MAX_FREQ      5'h10

// ----------------------------------------------------------------
// system code limits
// ----------------------------------------------------------------
`define ASP_SYS_MAX       5'h0B
`define ASP_SYS_AM_MAX    5'h02
`define ASP_SYS_FM1_MAX   5'h05
`define ASP_SYS_FM2_MAX   5'h08

// ----------------------------------------------------------------
// frequency grids, kHz
// ----------------------------------------------------------------
`define ASP_FM1_BASE      17'h155CC
`define ASP_FM2_BASE      17'h128E0
`define ASP_FM_STEP       17'h00064
`define ASP_FM1_MAX       8'hCC
`define ASP_FM2_MAX       8'h8C

// ----------------------------------------------------------------
// digital audio channel ranges
// ----------------------------------------------------------------
`define ASP_DAB_B1_HI     8'h0B
`define ASP_DAB_B3_LO     8'h40
`define ASP_DAB_B3_HI     8'h5F
`define ASP_DAB_B3X_HI    8'h65
`define ASP_DAB_LEU_LO    8'h80
`define ASP_DAB_LEU_HI    8'h8C
`define ASP_DAB_LCA_LO    8'hA0
`define ASP_DAB_LCA_HI    8'hB6

// ----------------------------------------------------------------
// character codes
// ----------------------------------------------------------------
`define ASP_HYPHEN        8'h2D
`define ASP_LOWER_A       8'h61
`define ASP_LOWER_Z       8'h7A

`endif

//--- inc/asp_pkg.sv
`include "asp_defines.svh"

package asp_pkg;

    // parser states, gray along idle-hdr-area-id-freq
    typedef enum logic [2:0] {
        ASP_S_IDLE = 3'h0,
        ASP_S_HDR  = 3'h1,
        ASP_S_AREA = 3'h3,
        ASP_S_ID   = 3'h2,
        ASP_S_FREQ = 3'h6,
        ASP_S_LANG = 3'h7,
        ASP_S_SKIP = 3'h5
    } asp_state_t;

    // band class of a digital audio channel code
    typedef enum logic [2:0] {
        ASP_DAB_NONE  = 3'h0,
        ASP_DAB_BAND1 = 3'h1,
        ASP_DAB_BAND3 = 3'h2,
        ASP_DAB_BAND3X = 3'h3,
        ASP_DAB_LEU   = 3'h4,
        ASP_DAB_LCA   = 3'h5
    } asp_dab_t;

    // identifier length for a system code, 0 when absent or reserved
    function automatic logic [5:0] asp_id_bits(input logic [4:0] sys);
        case (sys)
            5'h00, 5'h01, 5'h03, 5'h06, 5'h09: asp_id_bits = 6'h18;
            5'h04, 5'h07, 5'h0A:               asp_id_bits = 6'h10;
            5'h0B:                             asp_id_bits = 6'h20;
            default:                           asp_id_bits = 6'h00;
        endcase
    endfunction

    // width of one frequency entry
    function automatic logic [5:0] asp_freq_bits(input logic [4:0] sys);
        asp_freq_bits = (sys <= `ASP_SYS_AM_MAX) ? 6'h10 : 6'h08;
    endfunction

endpackage

//--- inc/asp_link_if.sv
`timescale 1ns/10ps

// bit-serial entity body link, msb first
interface asp_link_if (
    input wire logic sys_clk_i,
    input wire logic nrst_i
);
    logic       valid;
    logic       ready;
    logic       data;
    logic       last;
    logic [3:0] ent_type;

    modport dev (input valid, data, last, ent_type, output ready);
    modport src (output valid, data, last, ent_type, input ready);
endinterface

//--- hw/asp_entity_builder.sv
`timescale 1ns/10ps
`include "asp_defines.svh"

// sending end: assembles an entity body and shifts it out
module asp_entity_builder
    import asp_pkg::*;
(
    // clock and reset
    input  wire logic          sys_clk_i,
    input  wire logic          nrst_i,
    // user request
    input  wire logic          send_i,
    input  wire logic [3:0]    type_i,
    input  wire logic          notice_i,
    input  wire logic [1:0]    slot_i,
    input  wire logic          area_en_i,
    input  wire logic          same_prog_i,
    input  wire logic [4:0]    sys_i,
    input  wire logic [3:0]    area_i,
    input  wire logic [3:0]    tt_i,
    input  wire logic [31:0]   fsi_i,
    input  wire logic [4:0]    nfreq_i,
    input  wire logic [255:0]  freqs_i,
    input  wire logic [23:0]   lang_i,
    input  wire logic [15:0]   country_i,
    // user status
    output logic               busy_o,
    output logic               refused_o,
    // link
    asp_link_if.src            lk
);
    import asp_pkg::*;

    logic [`ASP_FRAME_W-1:0] frame;
    logic [8:0]              flen;
    logic [4:0]              nf;
    logic [5:0]              idw;
    logic [5:0]              fw;
    logic                    bad;
    logic [`ASP_FRAME_W-1:0] sh_q;
    logic [8:0]              rem_q;
    logic                    refused_q;

    // --------------------------------------------------------
    // body assembly
    // --------------------------------------------------------
    always_comb begin
        frame = '0;
        flen  = 9'h000;
        nf    = (nfreq_i > `ASP_MAX_FREQ) ? `ASP_MAX_FREQ : nfreq_i;
        idw   = asp_id_bits(sys_i);
        fw    = asp_freq_bits(sys_i);
        // refuse reserved code or empty entity
        bad   = (type_i == `ASP_TYPE_ALT) &&
                ((sys_i > `ASP_SYS_MAX) || (idw == 6'h00 && nf == 5'h00));
        case (type_i)
            `ASP_TYPE_ALT: begin
                frame = {308'h0, notice_i, slot_i, area_en_i, same_prog_i, 2'b00, sys_i};
                flen  = 9'h00C;
                if (area_en_i) begin
                    frame = (frame << 8) | {312'h0, area_i, tt_i};
                    flen  = flen + 9'h008;
                end
                if (idw != 6'h00) begin
                    frame = (frame << idw) |
                            ({288'h0, fsi_i} & ~({`ASP_FRAME_W{1'b1}} << idw));
                    flen  = flen + {3'h0, idw};
                end
                for (int k = 0; k < 16; k++) begin
                    if (5'(k) < nf) begin
                        frame = (frame << fw) | ((fw == 6'h10) ?
                                {305'h0, freqs_i[16*k +: 15]} :
                                {312'h0, freqs_i[16*k +: 8]});
                        flen  = flen + {3'h0, fw};
                    end
                end
            end
            `ASP_TYPE_LANG: begin
                frame = {276'h0, slot_i, 2'b00, lang_i, country_i};
                flen  = 9'h02C;
            end
            default: begin
                frame = '0;
                flen  = 9'h008;
            end
        endcase
    end

    // --------------------------------------------------------
    // serializer
    // --------------------------------------------------------
    // load on accepted request, one bit per taken beat
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            sh_q      <= '0;
            rem_q     <= 9'h000;
            refused_q <= 1'b0;
        end else begin
            refused_q <= send_i && (rem_q == 9'h000) && bad;
            if (send_i && rem_q == 9'h000 && !bad) begin
                sh_q  <= frame;
                rem_q <= flen;
            end else if (lk.valid && lk.ready) begin
                rem_q <= rem_q - 9'h001;
            end
        end
    end

    // link drive, msb of the remaining bits first
    assign lk.valid    = (rem_q != 9'h000);
    assign lk.data     = lk.valid ? sh_q[rem_q - 9'h001] : 1'b0;
    assign lk.last     = (rem_q == 9'h001);
    assign lk.ent_type = type_i;
    assign busy_o      = lk.valid;
    assign refused_o   = refused_q;

endmodule // asp_entity_builder

//--- sim/asp_link_chk.sv
`timescale 1ns/10ps

// link watcher between builder and parser
module asp_link_chk (
    // link signals
    input wire logic       sys_clk_i,
    input wire logic       nrst_i,
    input wire logic       valid,
    input wire logic       ready,
    input wire logic       data,
    input wire logic       last,
    input wire logic [3:0] ent_type
);
    logic [8:0]  pos_q;
    logic [11:0] hdr_q;
    logic        tk;

    assign tk = valid && ready;
    // bit index in the body, cleared on each last bit
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i || (tk && last)) pos_q <= 9'h000;
        else if (tk) pos_q <= pos_q + 9'h001;
    end
    // first twelve bits kept so later bits can be judged by the system code
    always_ff @(posedge sys_clk_i) begin
        if (tk && pos_q < 9'h00C) hdr_q <= {hdr_q[10:0], data};
    end

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    a_alt_spare_zero: assert property (
        tk && ent_type == 4'hB && pos_q inside {9'h005, 9'h006} |-> !data) else $error("spare set");
    a_lang_spare_zero: assert property (
        tk && ent_type == 4'hC && pos_q inside {9'h002, 9'h003} |-> !data) else $error("spare set");
    a_lang_len_ok: assert property (
        tk && ent_type == 4'hC |-> last == (pos_q == 9'h02B)) else $error("lang length");
    a_other_eight_zero: assert property (
        tk && !(ent_type inside {4'hB, 4'hC}) |-> !data && last == (pos_q == 9'h007))
        else $error("other body");
    a_alt_not_empty: assert property (
        tk && last && ent_type == 4'hB |-> pos_q >= 9'h013) else $error("alt too short");
    a_entry_whole: assert property (
        tk && last && ent_type == 4'hB && hdr_q[4:0] inside {[5'h03:5'h0B]} |-> pos_q[2:0] == 3'h3)
        else $error("partial entry");
    a_sys_defined: assert property (
        tk && ent_type == 4'hB && pos_q == 9'h00C |-> hdr_q[4:0] <= 5'h0B) else $error("reserved");
    a_type_steady: assert property (
        valid && !(ready && last) |=> $stable(ent_type)) else $error("type changed");
endmodule // asp_link_chk

//--- sim/tb.sv
`timescale 1ns/10ps

// builder and parser back to back, checked field by field
module tb;
    import asp_pkg::*;
    logic         sys_clk_i = '0, nrst_i = '0, send_i = '0, notice_i = '0, busy_o, refused_o;
    logic         area_en_i = '0, same_prog_i = '0, freq_valid_o, rec_valid_o, notice_o, err_o;
    logic         area_spec_o, tt_spec_o, same_prog_o, lang_unspec_o, country_unspec_o;
    logic [1:0]   slot_i = '0, slot_o;
    logic [3:0]   type_i = '0, area_i = '0, tt_i = '0, rec_type_o, area_o, tt_o;
    logic         area_en_o;
    logic [5:0]   fsi_bits_o;
    logic [7:0]   freq_code_o, fc[4];
    logic [4:0]   sys_i = '0, nfreq_i = '0, sys_o, nfreq_o;
    logic [15:0]  country_i = '0, country_o;
    logic [16:0]  freq_khz_o, fk[4];
    logic [23:0]  lang_i = '0, lang_o;
    logic [31:0]  fsi_i = '0, fsi_o;
    logic [255:0] freqs_i = '0;
    asp_dab_t     dab_band_o, fb[4];
    int           num_errors = 0, checks = 0, fn = 0;

    always #10 sys_clk_i = ~sys_clk_i;
    asp_link_if lk (.sys_clk_i, .nrst_i);
    asp_entity_builder asp_entity_builder_inst (.sys_clk_i, .nrst_i, .send_i, .type_i, .notice_i,
        .slot_i, .area_en_i, .same_prog_i, .sys_i, .area_i, .tt_i, .fsi_i, .nfreq_i, .freqs_i,
        .lang_i, .country_i, .busy_o, .refused_o, .lk);
    asp_entity_parser asp_entity_parser_inst (.sys_clk_i, .nrst_i, .lk, .freq_valid_o,
        .freq_code_o, .freq_khz_o, .dab_band_o, .rec_valid_o, .rec_type_o, .notice_o, .slot_o,
        .area_en_o, .area_o, .area_spec_o, .tt_o, .tt_spec_o, .same_prog_o, .sys_o, .fsi_o,
        .fsi_bits_o, .nfreq_o, .lang_o, .lang_unspec_o, .country_o, .country_unspec_o,
        .err_o);
    asp_link_chk asp_link_chk_inst (.sys_clk_i, .nrst_i, .valid(lk.valid), .ready(lk.ready),
        .data(lk.data), .last(lk.last), .ent_type(lk.ent_type));

    task automatic chk(input logic [31:0] got, exp, input string nm);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one request; bounded wait so a silent design cannot hang the run
    task automatic ent(input logic [3:0] t, input logic [17:0] h, input logic [31:0] id,
                       input logic [4:0] n, input logic [255:0] f);
        int k;
        type_i = t;
        {notice_i, slot_i, area_en_i, same_prog_i, sys_i, area_i, tt_i} = h;
        fsi_i = id;
        nfreq_i = n;
        freqs_i = f;
        fn = 0;
        send_i = 1'b1;
        @(negedge sys_clk_i);
        send_i = 1'b0;
        k = 0;
        // entry results taken mid-cycle while they stand, the last one with the record
        while (rec_valid_o !== 1'b1 && refused_o !== 1'b1 && k < 200) begin
            @(negedge sys_clk_i);
            k++;
            if (freq_valid_o === 1'b1) begin
                fk[fn] = freq_khz_o;
                fb[fn] = dab_band_o;
                fc[fn] = freq_code_o;
                fn++;
            end
        end
        if (k >= 200) num_errors++;
        $display("test with type %h system %h done", t, sys_i);
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #100000;
        num_errors++;
        complete_run;
    end

    initial begin
        repeat (4) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        ent(4'hB, {1'h1, 2'h2, 1'h1, 1'h1, 5'h0B, 4'h3, 4'h0}, 32'hE1C3A5F0, 5'h02, 256'hA00040);
        chk(notice_o, 1'h1, "notice");
        chk(slot_o, 2'h2, "slot");
        chk(area_spec_o, 1'h1, "area");
        chk(tt_spec_o, 1'h0, "timetable");
        chk(same_prog_o, 1'h1, "same");
        chk(fsi_o, 32'hE1C3A5F0, "id32");
        chk(nfreq_o, 5'h02, "count");
        chk(fb[0], ASP_DAB_BAND3, "band0");
        chk(fb[1], ASP_DAB_LCA, "band1");
        chk(fc[1], 8'hA0, "code1");
        chk(area_en_o, 1'h1, "area flag");
        chk(area_o, 4'h3, "area idx");
        ent(4'hB, {1'h0, 2'h1, 1'h0, 1'h0, 5'h03, 8'h00}, 32'h00E1C3A5, 5'h02, 256'hCD00CC);
        chk(fsi_o, 32'h00E1C3A5, "id24");
        chk(fsi_bits_o, 6'h18, "id len");
        chk(fk[0], 17'h1A57C, "grid1");
        chk(sys_o, 5'h03, "system");
        chk(notice_o, 1'h0, "notice");
        chk(err_o, 1'h1, "bad code");
        ent(4'hB, {1'h0, 2'h0, 1'h0, 1'h0, 5'h08, 8'h00}, 32'h0, 5'h01, 256'h8C);
        chk(fk[0], 17'h15F90, "grid2");
        chk(err_o, 1'h0, "err");
        ent(4'hB, {1'h0, 2'h0, 1'h1, 1'h0, 5'h02, 4'h0, 4'h7}, 32'h0, 5'h01, 256'hFFFF);
        chk(fk[0], 17'h07FFF, "khz");
        chk(area_spec_o, 1'h0, "area");
        chk(tt_spec_o, 1'h1, "timetable");
        chk(tt_o, 4'h7, "tt idx");
        ent(4'hB, {1'h0, 2'h0, 1'h0, 1'h0, 5'h0C, 8'h00}, 32'h0, 5'h01, 256'h1);
        chk(refused_o, 1'h1, "reserved");
        ent(4'hB, {1'h0, 2'h0, 1'h0, 1'h0, 5'h02, 8'h00}, 32'h0, 5'h00, 256'h0);
        chk(refused_o, 1'h1, "empty");
        lang_i = 24'h2D2D2D;
        country_i = 16'h6672;
        ent(4'hC, {1'h0, 2'h3, 15'h0000}, 32'h0, 5'h00, 256'h0);
        chk(slot_o, 2'h3, "lang slot");
        chk(lang_unspec_o, 1'h1, "lang");
        chk(country_unspec_o, 1'h0, "country");
        chk(lang_o, 24'h2D2D2D, "lang code");
        chk(country_o, 16'h6672, "country code");
        ent(4'h5, 18'h00000, 32'h0, 5'h00, 256'h0);
        chk(rec_type_o, 4'h5, "type");
        chk(err_o, 1'h0, "err");
        complete_run;
    end
endmodule // tb
